/* rtl/wrb_reg_bank.sv */
// Host register bank of the wireless receiver, written by the internal CPU
// on behalf of the serial host link, and consumed by the packet engine.
// Assumes location writes come from same-clock CPU logic; undervoltage
// comes from an analog comparator and is synchronised here.
`timescale 1ns/1ns
module wrb_reg_bank
    import wrb_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       srst_i,
    input  wire logic       uvlo_i,
    input  wire logic       wr_en_i,
    input  wire logic       rd_en_i,
    input  wire logic [7:0] loc_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       slot_free_i,
    input  wire logic       tx_present_i,
    input  wire logic       header_legal_i,
    input  wire logic       pkt_sent_i,
    input  wire logic       cpu_reset_i,
    output logic [7:0]      rdata_o,
    output logic            rvalid_o,
    output logic [6:0]      current_pct_o,
    output logic            pkt_start_o,
    output logic [7:0]      pkt_header_o,
    output logic            align_cep_zero_o,
    output wrb_power_ctl_t  power_ctl_o
);
    wrb_cur_cfg_t   cur_cfg;
    wrb_mailbox_t   mailbox;
    wrb_tuning_t    tuning;
    logic [7:0]     header;
    wrb_pkt_state_t state;
    wrb_pkt_state_t next_state;
    logic           uvlo_s;
    logic           high_clr;
    logic           wr_cfg;
    logic           wr_mb;
    logic           wr_tun;
    logic           wr_hdr;
    logic           req;
    logic           done_evt;
    logic [1:0]     done_err;

    wrb_sync2 u_uvlo_sync (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .d_i    (uvlo_i),
        .q_o    (uvlo_s)
    );

    assign high_clr = srst_i | uvlo_s;
    assign wr_cfg = wr_en_i && (loc_i == LOC_CUR_CFG);
    assign wr_mb  = wr_en_i && (loc_i == LOC_MAILBOX) && !uvlo_s;
    assign wr_tun = wr_en_i && (loc_i == LOC_TUNING) && !uvlo_s;
    assign wr_hdr = wr_en_i && (loc_i == LOC_HEADER) && !uvlo_s;
    // request is a zero written to done
    assign req = wr_mb && !wdata_i[MB_DONE_BIT];

    // Current configuration, outside the undervoltage domain
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cur_cfg <= CUR_CFG_RST;
        end else if (wr_cfg) begin
            cur_cfg <= wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            current_pct_o <= PCT_7;
        end else begin
            case (cur_cfg.output_current_selector)
                3'h0:    current_pct_o <= PCT_0;
                3'h1:    current_pct_o <= PCT_1;
                3'h2:    current_pct_o <= PCT_2;
                3'h3:    current_pct_o <= PCT_3;
                3'h4:    current_pct_o <= PCT_4;
                3'h5:    current_pct_o <= PCT_5;
                3'h6:    current_pct_o <= PCT_6;
                default: current_pct_o <= PCT_7;
            endcase
        end
    end

    // Tuning and header registers
    always_ff @(posedge clk_i) begin
        if (high_clr) begin
            tuning <= TUNING_RST;
            header <= HEADER_RST;
        end else begin
            if (wr_tun) begin
                tuning <= wdata_i;
            end
            if (wr_hdr) begin
                header <= wdata_i;
            end
        end
    end

    // Packet request sequencer
    always_comb begin
        next_state = state;
        done_evt   = 1'b0;
        done_err   = ERR_NONE;
        case (state)
            WRB_IDLE: begin
                if (req) begin
                    next_state = WRB_WAIT;
                end
            end
            WRB_WAIT: begin
                // hold until a slot frees up
                if (slot_free_i) begin
                    if (!header_legal_i) begin
                        next_state = WRB_IDLE;
                        done_evt   = 1'b1;
                        done_err   = ERR_ILLEGAL;
                    end else if (!tx_present_i) begin
                        next_state = WRB_IDLE;
                        done_evt   = 1'b1;
                        done_err   = ERR_NO_TX;
                    end else begin
                        next_state = WRB_SEND;
                    end
                end
            end
            WRB_SEND: begin
                if (pkt_sent_i) begin
                    next_state = WRB_IDLE;
                    done_evt   = 1'b1;
                end
            end
            default: next_state = WRB_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (high_clr) begin
            state <= WRB_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Mailbox register; completion wins over a same-cycle host write
    always_ff @(posedge clk_i) begin
        if (high_clr) begin
            mailbox <= MAILBOX_RST;
        end else begin
            if (wr_mb) begin
                mailbox.foreign_object_mail_bit  <= wdata_i[4];
                mailbox.align_mail_bit           <= wdata_i[MB_ALIGN_BIT];
                mailbox.foreign_object_scale_bit <= wdata_i[2];
                mailbox.reserved                 <= wdata_i[1:0];
            end else if (cpu_reset_i) begin
                mailbox.align_mail_bit <= 1'b0;
            end
            if (done_evt) begin
                mailbox.packet_done_flag   <= 1'b1;
                mailbox.packet_error_field <= done_err;
            end else if (req && state == WRB_IDLE) begin
                mailbox.packet_done_flag   <= 1'b0;
                mailbox.packet_error_field <= ERR_NONE;
            end
        end
    end

    // Packet launch towards the modulator
    always_ff @(posedge clk_i) begin
        if (high_clr) begin
            pkt_start_o  <= 1'b0;
            pkt_header_o <= HEADER_RST;
        end else begin
            pkt_start_o  <= (state == WRB_WAIT) && (next_state == WRB_SEND);
            pkt_header_o <= header;
        end
    end

    always_ff @(posedge clk_i) begin
        if (high_clr) begin
            align_cep_zero_o <= 1'b0;
        end else begin
            align_cep_zero_o <= mailbox.align_mail_bit;
        end
    end

    // Received power adjustments
    always_ff @(posedge clk_i) begin
        if (high_clr) begin
            power_ctl_o <= '0;
        end else begin
            power_ctl_o.loss_en   <= tuning.loss_resistance_enable;
            power_ctl_o.offset_en <= tuning.offset_enable;
            power_ctl_o.offset_mw <= 10'(OFFSET_STEP_MW
                                   * tuning.power_offset_field);
            case (tuning.loss_resistance_scale_field)
                3'h2:    power_ctl_o.loss_scale_half <= SCALE_X2;
                3'h3:    power_ctl_o.loss_scale_half <= SCALE_X3;
                3'h4:    power_ctl_o.loss_scale_half <= SCALE_X4;
                3'h7:    power_ctl_o.loss_scale_half <= SCALE_HALF;
                default: power_ctl_o.loss_scale_half <= SCALE_UNITY;
            endcase
            power_ctl_o.modified <= (tuning != TUNING_RST);
        end
    end

    // Read port; high bank reads reset values under undervoltage
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rdata_o  <= 8'h00;
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= rd_en_i;
            case (loc_i)
                LOC_CUR_CFG: rdata_o <= cur_cfg;
                LOC_MAILBOX: rdata_o <= mailbox;
                LOC_TUNING:  rdata_o <= tuning;
                LOC_HEADER:  rdata_o <= header;
                default:     rdata_o <= 8'h00;
            endcase
        end
    end
endmodule

/* rtl/wrb_pkg.sv */
// Constants, field layouts and carriers for the receiver host register bank.
// Assumes a single 20 MHz core clock and a byte-wide location/data port.
package wrb_pkg;
    localparam logic [7:0] LOC_CUR_CFG  = 8'h02;
    localparam logic [7:0] LOC_MAILBOX  = 8'hE0;
    localparam logic [7:0] LOC_TUNING   = 8'hE1;
    localparam logic [7:0] LOC_HEADER   = 8'hE2;
    localparam logic [7:0] LOC_HIGH_MIN = 8'hE0;
    localparam logic [7:0] CUR_CFG_RST  = 8'h07;
    localparam logic [7:0] MAILBOX_RST  = 8'h80;
    localparam logic [7:0] TUNING_RST   = 8'h00;
    localparam logic [7:0] HEADER_RST   = 8'h00;
    localparam int MB_DONE_BIT  = 7;
    localparam int MB_ALIGN_BIT = 3;
    localparam logic [1:0] ERR_NONE    = 2'h0;
    localparam logic [1:0] ERR_NO_TX   = 2'h1;
    localparam logic [1:0] ERR_ILLEGAL = 2'h2;
    localparam logic [9:0] OFFSET_STEP_MW = 10'h027; // 39 mW per code
    // Percent table for the output current selector, codes 0..7
    localparam logic [6:0] PCT_0 = 7'h0A;
    localparam logic [6:0] PCT_1 = 7'h14;
    localparam logic [6:0] PCT_2 = 7'h1E;
    localparam logic [6:0] PCT_3 = 7'h28;
    localparam logic [6:0] PCT_4 = 7'h32;
    localparam logic [6:0] PCT_5 = 7'h3C;
    localparam logic [6:0] PCT_6 = 7'h5A;
    localparam logic [6:0] PCT_7 = 7'h64;
    // Loss scale in halves: 2 = unity
    localparam logic [3:0] SCALE_UNITY = 4'h2;
    localparam logic [3:0] SCALE_X2    = 4'h4;
    localparam logic [3:0] SCALE_X3    = 4'h6;
    localparam logic [3:0] SCALE_X4    = 4'h8;
    localparam logic [3:0] SCALE_HALF  = 4'h1;

    typedef struct packed {
        logic [1:0] spare;        // bits 7..6, bit 7 temp_profile_unused_bit
        logic [2:0] term_current; // bits 5..3, stored only
        logic [2:0] output_current_selector;
    } wrb_cur_cfg_t;

    typedef struct packed {
        logic       packet_done_flag;
        logic [1:0] packet_error_field;
        logic       foreign_object_mail_bit;
        logic       align_mail_bit;
        logic       foreign_object_scale_bit;
        logic [1:0] reserved;
    } wrb_mailbox_t;

    typedef struct packed {
        logic       loss_resistance_enable;
        logic       offset_enable;
        logic [2:0] power_offset_field;
        logic [2:0] loss_resistance_scale_field;
    } wrb_tuning_t;

    // Power calculation controls handed to the internal CPU
    typedef struct packed {
        logic       loss_en;
        logic       offset_en;
        logic [9:0] offset_mw;
        logic [3:0] loss_scale_half;
        logic       modified;
    } wrb_power_ctl_t;

    typedef enum logic [1:0] {
        WRB_IDLE = 2'b00,
        WRB_WAIT = 2'b01,
        WRB_SEND = 2'b10
    } wrb_pkt_state_t;
endpackage

/* rtl/wrb_sync2.sv */
// Two-flop synchroniser for one level from outside the clock domain.
// Assumes the input is a slowly varying level such as a comparator output.
`timescale 1ns/1ns
module wrb_sync2 (
    input  wire logic clk_i,
    input  wire logic srst_i,
    input  wire logic d_i,
    output logic      q_o
);
    logic meta;

    // First stage feeds only the second
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            meta <= 1'b0;
            q_o  <= 1'b0;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule

/* testbench/wrb_reg_bank_props.sv */
// Port checker for the host register bank, bound to its top module.
// Assumes uvlo_i stays low around the location writes judged here.
`timescale 1ns/1ns
module wrb_reg_bank_props
    import wrb_pkg::*;
(
    input wire logic           clk_i,
    input wire logic           srst_i,
    input wire logic           uvlo_i,
    input wire logic           wr_en_i,
    input wire logic           rd_en_i,
    input wire logic [7:0]     loc_i,
    input wire logic [7:0]     wdata_i,
    input wire logic           slot_free_i,
    input wire logic           tx_present_i,
    input wire logic           header_legal_i,
    input wire logic           pkt_sent_i,
    input wire logic           cpu_reset_i,
    input wire logic [7:0]     rdata_o,
    input wire logic           rvalid_o,
    input wire logic [6:0]     current_pct_o,
    input wire logic           pkt_start_o,
    input wire logic [7:0]     pkt_header_o,
    input wire logic           align_cep_zero_o,
    input wire wrb_power_ctl_t power_ctl_o
);
    // Percent of limit per selector code
    localparam logic [6:0] PCT [8] = '{7'h0A, 7'h14, 7'h1E, 7'h28,
                                       7'h32, 7'h3C, 7'h5A, 7'h64};
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);

    read_answer_a: assert property (rd_en_i |=> rvalid_o)
        else $error("read not answered next cycle");
    pct_reset_a: assert property ($fell(srst_i) |->
        current_pct_o == 7'h64)
        else $error("selector percent not full after reset");
    pct_map_a: assert property (wr_en_i && loc_i == 8'h02 |->
        ##2 current_pct_o == PCT[$past(wdata_i[2:0], 2)])
        else $error("selector percent wrong");
    align_write_a: assert property (wr_en_i && loc_i == 8'hE0 |->
        ##2 align_cep_zero_o == $past(wdata_i[3], 2))
        else $error("alignment output not following mailbox");
    tune_fields_a: assert property (wr_en_i && loc_i == 8'hE1 |->
        ##2 power_ctl_o.offset_mw == 10'h027 * $past(wdata_i[5:3], 2)
        && {power_ctl_o.loss_en, power_ctl_o.offset_en}
        == $past(wdata_i[7:6], 2))
        else $error("power control not following tuning");
    start_slot_a: assert property (pkt_start_o |-> $past(slot_free_i)
        && $past(header_legal_i) && $past(tx_present_i))
        else $error("packet launched without free slot");
    start_pulse_a: assert property (pkt_start_o |=> !pkt_start_o)
        else $error("launch pulse too long");
    uvlo_clear_a: assert property (uvlo_i [*5] |->
        !align_cep_zero_o && power_ctl_o == '0)
        else $error("undervoltage did not clear upper bank");
endmodule

bind wrb_reg_bank wrb_reg_bank_props chk (.clk_i(clk_i), .srst_i(srst_i),
    .uvlo_i(uvlo_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .loc_i(loc_i),
    .wdata_i(wdata_i), .slot_free_i(slot_free_i), .rvalid_o(rvalid_o),
    .tx_present_i(tx_present_i), .header_legal_i(header_legal_i),
    .pkt_sent_i(pkt_sent_i), .cpu_reset_i(cpu_reset_i), .rdata_o(rdata_o),
    .current_pct_o(current_pct_o), .pkt_start_o(pkt_start_o),
    .pkt_header_o(pkt_header_o), .align_cep_zero_o(align_cep_zero_o),
    .power_ctl_o(power_ctl_o));

/* testbench/wrb_cpu_model.sv */
// CPU-side model: offers communication slots and reports sends.
// Assumes one-cycle launch pulses from the bank on the same clock.
`timescale 1ns/1ns
module wrb_cpu_model (
    input  wire logic clk_i,
    input  wire logic pkt_start_i,
    output logic      slot_free_o,
    output logic      pkt_sent_o
);
    logic [2:0] slot_cnt = 3'h0;
    logic [1:0] send_cnt = 2'h0;
    // slot one in eight
    // Rare slots force a request to wait, as a busy CPU would
    always @(posedge clk_i) begin
        slot_cnt <= slot_cnt + 3'h1;
    end
    assign slot_free_o = (slot_cnt == 3'h7);
    always @(posedge clk_i) begin
        if (pkt_start_i) begin
            send_cnt <= 2'h3;
        end else if (send_cnt != 2'h0) begin
            send_cnt <= send_cnt - 2'h1;
        end
    end
    assign pkt_sent_o = (send_cnt == 2'h1);
endmodule

/* testbench/wrb_reg_bank_tb.sv */
// Self-checking bench for the host register bank.
// Drives location strobes on falling edges; a CPU model serves slots.
`timescale 1ns/1ns
module wrb_reg_bank_tb
    import wrb_pkg::*;
;
    logic clk_i = 1'b0, srst_i = 1'b1, uvlo_i = 1'b0, cpu_reset_i = 1'b0;
    logic wr_en_i = 1'b0, rd_en_i = 1'b0, tx_present_i = 1'b1;
    logic header_legal_i = 1'b1, slot_free_i, pkt_sent_i, rvalid_o;
    logic pkt_start_o, align_cep_zero_o;
    logic [7:0] loc_i = 8'h00, wdata_i = 8'h00, rdata_o, pkt_header_o;
    logic [6:0] current_pct_o;
    wrb_power_ctl_t power_ctl_o;
    int n_errors = 0, tests_run = 0, n_start = 0;
    logic [6:0] pct [8] = '{7'h0A, 7'h14, 7'h1E, 7'h28,
                            7'h32, 7'h3C, 7'h5A, 7'h64};
    logic [3:0] scl [8] = '{4'h2, 4'h2, 4'h4, 4'h6, 4'h8, 4'h0, 4'h0, 4'h1};

    wrb_reg_bank uut (.clk_i(clk_i), .srst_i(srst_i), .uvlo_i(uvlo_i),
        .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .loc_i(loc_i),
        .wdata_i(wdata_i), .slot_free_i(slot_free_i),
        .tx_present_i(tx_present_i), .header_legal_i(header_legal_i),
        .pkt_sent_i(pkt_sent_i), .cpu_reset_i(cpu_reset_i),
        .rdata_o(rdata_o), .rvalid_o(rvalid_o),
        .current_pct_o(current_pct_o), .pkt_start_o(pkt_start_o),
        .pkt_header_o(pkt_header_o), .align_cep_zero_o(align_cep_zero_o),
        .power_ctl_o(power_ctl_o));
    wrb_cpu_model cpu (.clk_i(clk_i), .pkt_start_i(pkt_start_o),
        .slot_free_o(slot_free_i), .pkt_sent_o(pkt_sent_i));

    always #25 clk_i = ~clk_i;
    // Launch pulses counted for the packet outcome checks
    always @(posedge clk_i) begin
        if (pkt_start_o === 1'b1) n_start++;
    end

    task automatic chk(input logic [15:0] seen, exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] l, d);
        @(negedge clk_i);
        wr_en_i = 1'b1;
        loc_i = l;
        wdata_i = d;
        @(negedge clk_i);
        wr_en_i = 1'b0;
    endtask
    // Location held while the answer is taken
    task automatic rd(input logic [7:0] l, output logic [7:0] d);
        @(negedge clk_i);
        rd_en_i = 1'b1;
        loc_i = l;
        @(negedge clk_i);
        rd_en_i = 1'b0;
        d = rdata_o;
    endtask
    task automatic rc(input logic [7:0] l, exp, input string what);
        logic [7:0] v;
        rd(l, v);
        chk(v, exp, what);
    endtask
    // Header first, then request; poll until done comes back
    task automatic pkt(input logic tx, lg, input logic [7:0] exp);
        logic [7:0] v;
        int s;
        s = n_start;
        tx_present_i = tx;
        header_legal_i = lg;
        wr(8'hE2, 8'h5A);
        wr(8'hE0, 8'h00);
        v = 8'h00;
        for (int i = 0; i < 30 && v[7] !== 1'b1; i++) rd(8'hE0, v);
        chk(v, exp, "mailbox result");
        chk(n_start - s, tx && lg, "launches");
        chk(pkt_header_o, 8'h5A, "header");
    endtask
    task automatic close_out;
        if (n_errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        logic [7:0] v;
        repeat (3) @(negedge clk_i);
        srst_i = 1'b0;
        chk(current_pct_o, 7'h64, "pct reset");
        rc(8'h02, 8'h07, "cfg reset");
        rc(8'hE0, 8'h80, "mbox reset");
        rc(8'hE1, 8'h00, "tune reset");
        rc(8'h10, 8'h00, "unmapped");
        for (int i = 0; i < 8; i++) begin
            wr(8'h02, {5'h1F, i[2:0]});
            @(negedge clk_i);
            chk(current_pct_o, pct[i], "pct");
        end
        rc(8'h02, 8'hFF, "cfg spare");
        for (int i = 0; i < 8; i++) begin
            v = {i[1], i[0], i[2:0], i[2:0]};
            wr(8'hE1, v);
            @(negedge clk_i);
            chk(power_ctl_o.offset_mw, 10'(i) * 10'h027, "offset");
            chk({power_ctl_o.loss_en, power_ctl_o.offset_en}, v[7:6],
                "en");
            if (i != 5 && i != 6) begin
                chk(power_ctl_o.loss_scale_half, scl[i], "scl");
            end
            chk(power_ctl_o.modified, v != 8'h00, "modified");
        end
        wr(8'hE0, 8'h88);
        @(negedge clk_i);
        chk(align_cep_zero_o, 1'b1, "align on");
        rc(8'hE0, 8'h88, "mbox align");
        cpu_reset_i = 1'b1;
        @(negedge clk_i);
        cpu_reset_i = 1'b0;
        @(negedge clk_i);
        chk(align_cep_zero_o, 1'b0, "align off");
        pkt(1'b1, 1'b1, 8'h80);
        pkt(1'b0, 1'b1, 8'hA0);
        pkt(1'b1, 1'b0, 8'hC0);
        pkt(1'b0, 1'b0, 8'hC0);
        wr(8'hE1, 8'h12);
        uvlo_i = 1'b1;
        repeat (6) @(negedge clk_i);
        wr(8'h02, 8'h03);
        rc(8'hE1, 8'h00, "tune uvlo");
        rc(8'hE0, 8'h80, "mbox uvlo");
        rc(8'h02, 8'h03, "cfg uvlo");
        uvlo_i = 1'b0;
        repeat (4) @(negedge clk_i);
        rc(8'hE2, 8'h00, "hdr uvlo");
        close_out;
    end
    // Tests need under 2000 cycles; a hang is cut at 20000
    initial begin
        #(50 * 20000);
        n_errors++;
        close_out;
    end
endmodule
